//--- src/ihsm_master.sv
// High-speed mode script master: pullups, mode, start, preamble, rate
// Assumes open-drain SDA/SCL resolved outside; one command at a time
`timescale 1ns/10ps
`include "ihsm_defines.svh"
module ihsm_master
    import ihsm_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_CYC = `IHSM_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Command port
    input wire logic CMD_VALID_IN,
    input wire ihsm_cmd_t CMD_IN,
    output logic CMD_READY_OUT,
    output logic CMD_DONE_OUT,
    // Status
    output logic ERROR_OUT,
    output ihsm_err_t ERR_CODE_OUT,
    output logic WARN_OUT,
    input wire logic ERR_CLEAR_IN,
    output logic PULLUP_EN_OUT,
    output logic HIGH_SPEED_MODE_SELECT_OUT,
    output logic HS_ACTIVE_OUT,
    output logic [15:0] HIGH_SPEED_BIT_RATE_OUT,
    // Bus lines, open drain
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT
);

    // Bit engine states
    typedef enum logic [2:0] {
        S_IDLE, S_FREE, S_START_A, S_START_B, S_LOW, S_HIGH
    } ihsm_state_t;

    ihsm_state_t state_q, state_d;   // Engine state
    logic scl_s, sda_s;              // Synchronised lines
    logic [8:0] div_q, div_d;        // Half-period divider
    logic [8:0] hs_half_q, hs_half_d; // Chosen high speed half period
    logic [31:0] to_q, to_d;         // Free-bus timeout count
    logic [11:0] free_q, free_d;     // Lines-high run length
    logic [7:0] code_q, code_d;      // Preamble shift register
    logic [3:0] bit_q, bit_d;        // Bit index, 8 is the ack slot
    logic err_set, warn_set;         // Error and warning events
    ihsm_err_t err_code_d;           // Code for a new error
    logic err_d, warn_d, done_d, ready_d;
    logic pull_d, mode_d, act_d, scl_oe_d, sda_oe_d;
    logic [15:0] rate_d;

    // Line synchronisers
    ihsm_sync u_scl_sync (
        .clk_in(CLK_IN), .rst_n_in(RST_N_IN),
        .async_in(SCL_IN), .sync_out(scl_s)
    );
    ihsm_sync u_sda_sync (
        .clk_in(CLK_IN), .rst_n_in(RST_N_IN),
        .async_in(SDA_IN), .sync_out(sda_s)
    );

    // Command decode
    wire accept = CMD_VALID_IN && CMD_READY_OUT;
    wire [15:0] req = CMD_IN.arg;
    wire [8:0] half_sel = HS_ACTIVE_OUT ? hs_half_q :
        9'(`IHSM_HALF_CYC(`IHSM_FS_KHZ));
    wire tick = (div_q == half_sel - 9'h001);
    wire to_hit = (to_q == TIMEOUT_CYC - 32'h1);
    wire lines_high = scl_s && sda_s;
    wire free_hit = (free_q == 12'(`IHSM_FREE_CYC) - 12'h001) && lines_high;

    wire [15:0] sel_khz = (req >= 16'(`IHSM_HS_KHZ_0)) ? 16'(`IHSM_HS_KHZ_0) :
        (req >= 16'(`IHSM_HS_KHZ_1)) ? 16'(`IHSM_HS_KHZ_1) :
        16'(`IHSM_HS_KHZ_2);
    wire [8:0] sel_half = (req >= 16'(`IHSM_HS_KHZ_0)) ?
        9'(`IHSM_HALF_CYC(`IHSM_HS_KHZ_0)) :
        (req >= 16'(`IHSM_HS_KHZ_1)) ? 9'(`IHSM_HALF_CYC(`IHSM_HS_KHZ_1)) :
        9'(`IHSM_HALF_CYC(`IHSM_HS_KHZ_2));
    wire rate_low = req < 16'(`IHSM_HS_KHZ_2);

    // Next-state logic of the engine and settings
    always_comb begin
        state_d = state_q;
        div_d = (state_q == S_IDLE || state_q == S_FREE || tick) ? 9'h000 :
            div_q + 9'h001;
        hs_half_d = hs_half_q;
        to_d = to_q;
        free_d = free_q;
        code_d = code_q;
        bit_d = bit_q;
        err_set = 1'b0;
        warn_set = 1'b0;
        err_code_d = ERR_CODE_OUT;
        done_d = 1'b0;
        pull_d = PULLUP_EN_OUT;
        mode_d = HIGH_SPEED_MODE_SELECT_OUT;
        act_d = HS_ACTIVE_OUT;
        rate_d = HIGH_SPEED_BIT_RATE_OUT;
        scl_oe_d = SCL_OE_OUT;
        sda_oe_d = SDA_OE_OUT;
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    done_d = 1'b1;
                    if (CMD_IN.op == OP_PULLUP) begin
                        pull_d = req[0];
                    end else if (CMD_IN.op == OP_MODE) begin
                        mode_d = req[0];
                        act_d = HS_ACTIVE_OUT && req[0];
                    end else if (CMD_IN.op == OP_START) begin
                        done_d = 1'b0;
                        state_d = S_FREE;
                        to_d = 32'h0;
                        free_d = 12'h000;
                        scl_oe_d = 1'b0;
                        sda_oe_d = 1'b0;
                    end else if (!HIGH_SPEED_MODE_SELECT_OUT &&
                        (CMD_IN.op == OP_PREAMBLE || CMD_IN.op == OP_RATE)) begin
                        done_d = 1'b0;
                        err_set = 1'b1;
                        err_code_d = ERR_MODE_OFF;
                    end else if (CMD_IN.op == OP_PREAMBLE) begin
                        // fixed upper bits; start already on bus
                        done_d = 1'b0;
                        code_d = {`IHSM_CODE_TOP, req[2:0]};
                        bit_d = 4'h0;
                        act_d = 1'b0;
                        sda_oe_d = 1'b1;
                        state_d = S_LOW;
                    end else if (CMD_IN.op == OP_RATE) begin
                        if (rate_low) begin
                            done_d = 1'b0;
                            err_set = 1'b1;
                            err_code_d = ERR_RATE_LOW;
                        end else begin
                            rate_d = sel_khz;
                            hs_half_d = sel_half;
                            warn_set = (sel_khz != req);
                        end
                    end
                end
            end
            S_FREE: begin
                to_d = to_q + 32'h1;
                free_d = lines_high ? free_q + 12'h001 : 12'h000;
                if (free_hit) begin
                    sda_oe_d = 1'b1;
                    state_d = S_START_A;
                end else if (to_hit) begin
                    err_set = 1'b1;
                    err_code_d = ERR_BUS_TIMEOUT;
                    state_d = S_IDLE;
                end
            end
            S_START_A: begin
                // Hold SDA low with SCL high, then pull SCL
                if (tick) begin
                    scl_oe_d = 1'b1;
                    state_d = S_START_B;
                end
            end
            S_START_B: begin
                if (tick) begin
                    done_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_LOW: begin
                // Data set; release SCL after half period
                if (tick) begin
                    scl_oe_d = 1'b0;
                    state_d = S_HIGH;
                end
            end
            default: begin
                // S_HIGH: end of high half, pull SCL low, except when the ack slot is acknowledged (SCL released)
                if (tick) begin
                    scl_oe_d = 1'b1;
                    state_d = S_LOW;
                    if (bit_q == `IHSM_ACK_IDX) begin
                        state_d = S_IDLE;
                        if (!sda_s) begin
                            err_set = 1'b1;
                            err_code_d = ERR_PREAMBLE_ACKED;
                            scl_oe_d = 1'b0;
                        end else begin
                            // high speed rate from now on
                            act_d = 1'b1;
                            done_d = 1'b1;
                        end
                    end else begin
                        bit_d = bit_q + 4'h1;
                        code_d = {code_q[6:0], 1'b0};
                        sda_oe_d = (bit_q == 4'h7) ? 1'b0 : !code_q[6];
                    end
                end
            end
        endcase
        // Set wins over clear
        err_d = err_set || (ERROR_OUT && !ERR_CLEAR_IN);
        warn_d = warn_set || (WARN_OUT && !ERR_CLEAR_IN);
        if (!err_d && !err_set) begin
            err_code_d = ERR_NONE;
        end
        ready_d = (state_d == S_IDLE) && !err_d;
    end

    // Engine registers
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= S_IDLE;
            div_q <= 9'h000;
            to_q <= 32'h0;
            free_q <= 12'h000;
            code_q <= 8'h00;
            bit_q <= 4'h0;
            hs_half_q <= 9'(`IHSM_HALF_CYC(`IHSM_HS_KHZ_2));
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            to_q <= to_d;
            free_q <= free_d;
            code_q <= code_d;
            bit_q <= bit_d;
            hs_half_q <= hs_half_d;
        end
    end

    // Output registers
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            CMD_READY_OUT <= 1'b0;
            CMD_DONE_OUT <= 1'b0;
            ERROR_OUT <= 1'b0;
            ERR_CODE_OUT <= ERR_NONE;
            WARN_OUT <= 1'b0;
            PULLUP_EN_OUT <= 1'b0;
            HIGH_SPEED_MODE_SELECT_OUT <= 1'b0;
            HS_ACTIVE_OUT <= 1'b0;
            HIGH_SPEED_BIT_RATE_OUT <= 16'(`IHSM_HS_KHZ_2);
            SCL_OUT <= 1'b0;
            SCL_OE_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE_OUT <= 1'b0;
        end else begin
            CMD_READY_OUT <= ready_d;
            CMD_DONE_OUT <= done_d;
            ERROR_OUT <= err_d;
            ERR_CODE_OUT <= err_code_d;
            WARN_OUT <= warn_d;
            PULLUP_EN_OUT <= pull_d;
            HIGH_SPEED_MODE_SELECT_OUT <= mode_d;
            HS_ACTIVE_OUT <= act_d;
            HIGH_SPEED_BIT_RATE_OUT <= rate_d;
            SCL_OE_OUT <= scl_oe_d;
            SDA_OE_OUT <= sda_oe_d;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire shifting = (state_q == S_LOW || state_q == S_HIGH);

    a_pullup_follow: assert property (accept && CMD_IN.op == OP_PULLUP
        |=> PULLUP_EN_OUT == $past(req[0])) else $error("pullup mismatch");
    a_mode_follow: assert property (accept && CMD_IN.op == OP_MODE
        |=> HIGH_SPEED_MODE_SELECT_OUT == $past(req[0]))
        else $error("mode mismatch");
    a_mode_guard: assert property (accept && !HIGH_SPEED_MODE_SELECT_OUT &&
        (CMD_IN.op == OP_PREAMBLE || CMD_IN.op == OP_RATE)
        |=> ERROR_OUT && ERR_CODE_OUT == ERR_MODE_OFF && state_q == S_IDLE)
        else $error("guard failed");
    a_code_top: assert property (shifting && bit_q == 4'h0
        |-> code_q[7:3] == `IHSM_CODE_TOP) else $error("bad preamble top");
    a_ack_halt: assert property (state_q == S_HIGH && tick &&
        bit_q == `IHSM_ACK_IDX && !sda_s
        |=> ERROR_OUT && ERR_CODE_OUT == ERR_PREAMBLE_ACKED && !HS_ACTIVE_OUT
        ##1 !CMD_READY_OUT) else $error("ack not halted");
    a_nack_active: assert property (state_q == S_HIGH && tick &&
        bit_q == `IHSM_ACK_IDX && sda_s |=> HS_ACTIVE_OUT && CMD_DONE_OUT)
        else $error("nack not handled");
    a_rate_round: assert property (accept && CMD_IN.op == OP_RATE &&
        HIGH_SPEED_MODE_SELECT_OUT && !rate_low
        |=> HIGH_SPEED_BIT_RATE_OUT <= $past(req) && WARN_OUT ==
        ($past(req) != HIGH_SPEED_BIT_RATE_OUT || $past(WARN_OUT) &&
        !$past(ERR_CLEAR_IN))) else $error("rate rounding");
    a_rate_top: assert property (accept && CMD_IN.op == OP_RATE &&
        HIGH_SPEED_MODE_SELECT_OUT && req >= 16'(`IHSM_HS_KHZ_0)
        |=> HIGH_SPEED_BIT_RATE_OUT == 16'(`IHSM_HS_KHZ_0))
        else $error("top rate");
    a_rate_low: assert property (accept && CMD_IN.op == OP_RATE &&
        HIGH_SPEED_MODE_SELECT_OUT && rate_low
        |=> ERROR_OUT && $stable(HIGH_SPEED_BIT_RATE_OUT))
        else $error("low rate accepted");
    a_bus_timeout: assert property (state_q == S_FREE && to_hit &&
        !free_hit |=> ERR_CODE_OUT == ERR_BUS_TIMEOUT ##1 state_q == S_IDLE)
        else $error("timeout missed");
    a_fast_preamble: assert property (shifting
        |-> half_sel == 9'(`IHSM_HALF_CYC(`IHSM_FS_KHZ)) && !HS_ACTIVE_OUT)
        else $error("preamble not at fast rate");

    c_preamble_nack: cover property (state_q == S_HIGH && tick &&
        bit_q == `IHSM_ACK_IDX && sda_s);
    c_start_done: cover property (state_q == S_START_B ##1 CMD_DONE_OUT);
    c_rate_warn: cover property (accept && CMD_IN.op == OP_RATE ##1 WARN_OUT);

endmodule

//--- shared/ihsm_defines.svh
// Timing counts, code layout and rate table for the high-speed script master
// Assumes a 4 ns core clock; included by the master by its bare name
`ifndef IHSM_DEFINES_SVH
`define IHSM_DEFINES_SVH

// Core clock period in ns
`define IHSM_CLK_NS 4
// Longest wait for a free bus, in ns, and its count of cycles
`define IHSM_TIMEOUT_NS 1000000000
`define IHSM_TIMEOUT_CYC (`IHSM_TIMEOUT_NS / `IHSM_CLK_NS)
// Least time both lines stay high before the bus counts as free
`define IHSM_FREE_NS 4700
`define IHSM_FREE_CYC ((`IHSM_FREE_NS + `IHSM_CLK_NS - 1) / `IHSM_CLK_NS)
// Half bit period in cycles for a rate in kHz, rounded up
`define IHSM_HALF_CYC(k) ((1000000 + 2*(k)*`IHSM_CLK_NS - 1) / (2*(k)*`IHSM_CLK_NS))
// Standard/fast rate used for the preamble byte, kHz
`define IHSM_FS_KHZ 400
// Supported high speed rates, kHz, highest first
`define IHSM_HS_KHZ_0 3400
`define IHSM_HS_KHZ_1 1700
`define IHSM_HS_KHZ_2 1000
// Fixed upper five bits of the preamble byte
`define IHSM_CODE_TOP 5'h01
// Bit index of the acknowledge slot
`define IHSM_ACK_IDX 4'h8

`endif

//--- shared/ihsm_pkg.sv
// Types shared by the high-speed script master and its bench
// Assumes nothing of its surroundings
package ihsm_pkg;

    // Script commands handled here
    typedef enum logic [2:0] {
        OP_PULLUP,
        OP_MODE,
        OP_START,
        OP_PREAMBLE,
        OP_RATE
    } ihsm_op_t;

    // Error codes; any error halts the script
    typedef enum logic [2:0] {
        ERR_NONE,
        ERR_BUS_TIMEOUT,
        ERR_MODE_OFF,
        ERR_PREAMBLE_ACKED,
        ERR_RATE_LOW
    } ihsm_err_t;

    // One script command: opcode and argument
    typedef struct packed {
        ihsm_op_t op;
        logic [15:0] arg;
    } ihsm_cmd_t;

endpackage

//--- src/ihsm_sync.sv
// Two-stage synchroniser for one asynchronous level
// Assumes the destination clock is the only clock in use
`timescale 1ns/10ps
module ihsm_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Async level and its synchronised copy
    input wire logic async_in,
    output logic sync_out
);

    // First stage, read only by the second
    logic meta_q;

    // Two flops in series; lines idle high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

//--- bench/ihsm_slave_model.sv
// Behavioural slave on the shared bus, answering the preamble ack slot
// Assumes resolved open-drain lines with external pull-ups
`timescale 1ns/10ps
module ihsm_slave_model (
    // Resolved bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // Acknowledge the byte when high
    input wire logic ack_en_in,
    // High while pulling data low
    output logic sda_oe_out
);
    // Clock rises seen since the last start
    int bits;

    initial begin
        bits = 0;
        sda_oe_out = 1'b0;
    end

    // Start condition restarts the bit count
    always @(negedge sda_in) begin
        if (scl_in === 1'b1) begin
            bits = 0;
        end
    end

    // Count bits on each rising clock
    always @(posedge scl_in) begin
        bits = bits + 1;
    end

    // Pull data low over the ninth bit only, if asked to
    always @(negedge scl_in) begin
        sda_oe_out <= ack_en_in && (bits == 8);
    end
endmodule

//--- bench/i2c_hs_mode_script_master_test.sv
// Self-checking bench for the high-speed script master
// Assumes a slave model on the lines and external pull-ups
`timescale 1ns/10ps
module i2c_hs_mode_script_master_test;
    import ihsm_pkg::*;
    // Stimulus
    logic clk, rst_n, valid, clr, hold_sda, ack_en;
    ihsm_cmd_t cmd;
    // Design outputs
    wire logic rdy, done, err, warn, pu, mode, hs;
    wire logic scl_oe, sda_oe, slv_oe, scl_o, sda_o;
    wire ihsm_err_t code;
    wire logic [15:0] rate;
    // Results and bookkeeping
    logic [8:0] cap;
    logic got_done, got_err;
    int mismatches, n_compared, got_cyc;

    // Open-drain lines with external pull-ups
    wire logic scl = ~scl_oe;
    wire logic sda = ~(sda_oe | slv_oe | hold_sda);

    ihsm_master #(.TIMEOUT_CYC(32'd2000)) dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(valid),
        .CMD_IN(cmd), .CMD_READY_OUT(rdy), .CMD_DONE_OUT(done),
        .ERROR_OUT(err), .ERR_CODE_OUT(code), .WARN_OUT(warn),
        .ERR_CLEAR_IN(clr), .PULLUP_EN_OUT(pu),
        .HIGH_SPEED_MODE_SELECT_OUT(mode), .HS_ACTIVE_OUT(hs),
        .HIGH_SPEED_BIT_RATE_OUT(rate), .SCL_IN(scl), .SCL_OUT(scl_o),
        .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe));

    ihsm_slave_model slave (.scl_in(scl), .sda_in(sda),
        .ack_en_in(ack_en), .sda_oe_out(slv_oe));

    // Core clock, 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Shift in the data level at each rising bus clock
    always @(posedge scl) cap <= {cap[7:0], sda};

    // Compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask

    // Offer one command, wait for done or error within lim cycles
    task automatic run(input ihsm_op_t op, input logic [15:0] arg,
                       input int lim);
        int n;
        n = 0;
        valid = 1'b1;
        cmd = '{op, arg};
        while (rdy !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) begin
            mismatches++;
            $display("mismatch at %0t: never ready", $time);
            report_and_stop();
        end
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && err !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        got_done = done;
        got_err = err;
        got_cyc = n;
        if (n >= lim) begin
            mismatches++;
            $display("mismatch at %0t: no answer", $time);
            report_and_stop();
        end
        @(negedge clk);
    endtask

    // Clear a held error or warning
    task automatic clear();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        chk(16'(err), 16'h0, "error cleared");
        chk(16'(warn), 16'h0, "warning cleared");
    endtask

    // Pullups on then off
    task automatic t_pullup();
        run(OP_PULLUP, 16'h0001, 4);
        chk(16'(got_done), 16'h1, "pullup done");
        chk(16'(pu), 16'h1, "pullup on");
        run(OP_PULLUP, 16'h0000, 4);
        chk(16'(pu), 16'h0, "pullup off");
    endtask

    // Preamble and rate refused while mode is off
    task automatic t_refuse();
        run(OP_PREAMBLE, 16'h0005, 4);
        chk(16'(code), 16'(ERR_MODE_OFF), "preamble mode off");
        chk(16'(rdy), 16'h0, "halted on error");
        clear();
        run(OP_RATE, 16'd3400, 4);
        chk(16'(code), 16'(ERR_MODE_OFF), "rate mode off");
        chk(rate, 16'd1000, "rate kept");
        clear();
    endtask

    // Mode toggles, rate table, round down and too low
    task automatic t_rate();
        logic [15:0] req[4] = '{16'd3400, 16'd2000, 16'd1000, 16'd1700};
        logic [15:0] exp[4] = '{16'd3400, 16'd1700, 16'd1000, 16'd1700};
        logic w[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        run(OP_MODE, 16'h0001, 4);
        chk(16'(mode), 16'h1, "mode on");
        for (int i = 0; i < 4; i++) begin
            run(OP_RATE, req[i], 4);
            chk(rate, exp[i], "rate chosen");
            chk(16'(warn), 16'(w[i]), "rate warning");
            if (w[i]) begin
                clear();
            end
        end
        run(OP_RATE, 16'd999, 4);
        chk(16'(code), 16'(ERR_RATE_LOW), "rate too low");
        chk(rate, 16'd1700, "low rate ignored");
        clear();
        run(OP_MODE, 16'h0000, 4);
        chk(16'(mode), 16'h0, "mode off");
        run(OP_MODE, 16'h0001, 4);
    endtask

    // Data held low: start must time out
    task automatic t_timeout();
        hold_sda = 1'b1;
        run(OP_START, 16'h0000, 2500);
        chk(16'(code), 16'(ERR_BUS_TIMEOUT), "bus timeout");
        chk(16'(got_cyc >= 1900), 16'h1, "timeout length");
        hold_sda = 1'b0;
        clear();
    endtask

    // Start, then preamble answered with or without acknowledge
    task automatic t_code(input logic ack, input logic [15:0] arg);
        run(OP_START, 16'h0000, 4000);
        chk(16'(got_done), 16'h1, "start done");
        chk(16'(got_cyc >= 1175), 16'h1, "free wait");
        ack_en = ack;
        run(OP_PREAMBLE, arg, 7000);
        chk(16'(cap[8:1]), {8'h0, 5'h01, arg[2:0]}, "code byte");
        chk(16'(cap[0]), {15'h0, ~ack}, "ack slot");
        chk(16'(got_cyc >= 5600), 16'h1, "fast rate");
        if (ack) begin
            chk(16'(code), 16'(ERR_PREAMBLE_ACKED), "acked");
            chk(16'(hs), 16'h0, "no high speed");
            chk(16'(rdy), 16'h0, "script halted");
            clear();
        end else begin
            chk(16'(got_done), 16'h1, "preamble done");
            chk(16'(hs), 16'h1, "high speed on");
        end
        ack_en = 1'b0;
    endtask

    // Mid-run reset returns settings and lines to their defaults
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(16'(mode), 16'h0, "mode after reset");
        chk(rate, 16'd1000, "rate after reset");
        chk(16'(err), 16'h0, "error after reset");
        chk(16'(rdy), 16'h1, "ready after reset");
        chk({14'h0, scl_o, sda_o}, 16'h0, "drive levels");
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        valid = 1'b0;
        clr = 1'b0;
        hold_sda = 1'b0;
        ack_en = 1'b0;
        cap = 9'h000;
        cmd = '{OP_PULLUP, 16'h0000};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(rate, 16'd1000, "reset rate");
        chk(16'(rdy), 16'h1, "ready after release");
        t_pullup();
        t_refuse();
        t_rate();
        t_timeout();
        t_code(1'b0, 16'h0005);
        t_code(1'b1, 16'h0002);
        t_reset();
        report_and_stop();
    end
endmodule
